// ==== logic/epg_pkg.sv ====
// Package with constants and types for the EEPROM power and access guard.
package epg_pkg;
   localparam int EPG_ADDR_W      = 7;
   localparam int EPG_DATA_W      = 8;
   localparam int EPG_PROG_CYCLES = 16;
   localparam int EPG_ERASE_CYC   = 1;
   localparam logic [7:0] EPG_ERASED_BYTE = 8'hFF;
   localparam logic [7:0] EPG_RESET_BYTE  = 8'h00;

   typedef enum logic [4:0] {
      EPG_IDLE  = 5'h01,
      EPG_PROG  = 5'h02,
      EPG_WAIT  = 5'h04,
      EPG_HALT  = 5'h08,
      EPG_ERASE = 5'h10
   } epg_state_e;
endpackage

// ==== logic/epg_array.sv ====
// Byte-wide flip-flop storage that models the EEPROM cells.
`timescale 1ns/1ps
module epg_array
   import epg_pkg::*;
#(
   parameter int DEPTH = 1 << EPG_ADDR_W
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  wr_en,
   input  wire logic                  clr_all,
   input  wire logic [EPG_ADDR_W-1:0] wr_addr,
   input  wire logic [EPG_DATA_W-1:0] wr_data,
   input  wire logic [EPG_ADDR_W-1:0] rd_addr,
   output logic      [EPG_DATA_W-1:0] rd_data
);
   typedef struct packed {
      logic [DEPTH-1:0][EPG_DATA_W-1:0] mem;
      logic [EPG_DATA_W-1:0]            rd;
   } epg_array_s;

   epg_array_s st;
   epg_array_s next_st;

   always_comb begin
      next_st = st;
      if (clr_all) begin
         for (int i = 0; i < DEPTH; i++) begin
            next_st.mem[i] = EPG_ERASED_BYTE;
         end
      end else if (wr_en) begin
         next_st.mem[wr_addr] = wr_data;
      end
      next_st.rd = st.mem[rd_addr];
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{default: '1};
      end else begin
         st <= next_st;
      end
   end

   assign rd_data = st.rd;
endmodule // epg_array

// ==== logic/epg_guard.sv ====
// Top of the EEPROM power and access guard.
//
// Overview of operation
// - Wait request on wait instruction or active-halt.
// - Wait deferred until running programming cycle ends.
// - Halt instruction enters halt immediately, aborting.
// - Latch mode set: reads leave bus undriven.
// - Latch mode clear: writes capture nothing.
// - Reset during programming leaves data unguaranteed.
// - Protection blocks external read-out and rewriting.
// - Removing protection first erases both memories.
// - One option bit protects both memories together.
`timescale 1ns/1ps
module epg_guard
   import epg_pkg::*;
#(
   parameter int PROG_CYCLES = EPG_PROG_CYCLES
) (
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   input  wire logic                  wait_for_interrupt_instr,
   input  wire logic                  active_halt_entry,
   input  wire logic                  halt_instr,
   input  wire logic                  wake_event,
   input  wire logic                  eeprom_latch_mode,
   input  wire logic                  prog_start,
   input  wire logic                  bus_rd,
   input  wire logic                  bus_wr,
   input  wire logic [EPG_ADDR_W-1:0] bus_addr,
   input  wire logic [EPG_DATA_W-1:0] bus_wdata,
   input  wire logic                  external_access,
   input  wire logic                  readout_protect_opt,
   input  wire logic                  option_reprogram,
   output logic      [EPG_DATA_W-1:0] bus_rdata,
   output logic                       bus_rdata_oe,
   output logic                       prog_busy,
   output logic                       eeprom_in_wait,
   output logic                       eeprom_in_halt,
   output logic                       program_mem_erase,
   output logic                       protect_active
);
   localparam int CNT_W = $clog2(PROG_CYCLES + 1);

   typedef struct packed {
      epg_state_e            state;
      logic                  wait_pend;
      logic [CNT_W-1:0]      cnt;
      logic [EPG_DATA_W-1:0] lat_data;
      logic [EPG_ADDR_W-1:0] lat_addr;
      logic                  lat_valid;
      logic                  rd_oe;
      logic                  protect;
      logic                  pm_erase;
   } epg_guard_s;

   epg_guard_s st;
   epg_guard_s next_st;
   logic       rst_n;
   logic       arr_wr;
   logic       arr_clr;
   logic       blocked;
   // The reset synchroniser runs on the raw reset, so it lives outside the state struct.
   logic [1:0] rst_sync;

   // Wait is requested by the wait instruction or by active-halt entry.
   function automatic logic wait_request(
      input logic wait_instr,
      input logic ahalt_entry
   );
      return wait_instr || ahalt_entry;
   endfunction

   // A read may drive the data bus only in read mode and when not blocked.
   function automatic logic read_allowed(
      input logic latch_mode,
      input logic blk
   );
      return !latch_mode && !blk;
   endfunction

   // Bus data reaches the write latch only in latch mode, unblocked and between cycles.
   function automatic logic write_allowed(
      input logic       latch_mode,
      input logic       blk,
      input epg_state_e cur
   );
      return latch_mode && !blk && (cur != EPG_PROG);
   endfunction

   // A programming cycle needs a latched byte and no protection in force.
   function automatic logic prog_allowed(
      input logic have_byte,
      input logic prot
   );
      return have_byte && !prot;
   endfunction

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   assign rst_n = rst_sync[1];
   // Protection covers program memory and EEPROM together.
   assign blocked = st.protect && external_access;

   always_comb begin
      next_st          = st;
      arr_wr           = 1'b0;
      arr_clr          = 1'b0;
      next_st.pm_erase = 1'b0;
      next_st.rd_oe    = bus_rd && read_allowed(eeprom_latch_mode, blocked);
      if (wait_request(wait_for_interrupt_instr, active_halt_entry)) begin
         next_st.wait_pend = 1'b1;
      end
      if (bus_wr && write_allowed(eeprom_latch_mode, blocked, st.state)) begin
         next_st.lat_data  = bus_wdata;
         next_st.lat_addr  = bus_addr;
         next_st.lat_valid = 1'b1;
      end
      if (option_reprogram && st.protect && !readout_protect_opt) begin
         // Protection removal wipes both memories before unlocking.
         next_st.state    = EPG_ERASE;
         next_st.pm_erase = 1'b1;
      end else if (halt_instr) begin
         // Any cycle in progress is dropped; its cells may be corrupted.
         next_st.state     = EPG_HALT;
         next_st.cnt       = '0;
         next_st.wait_pend = 1'b0;
         next_st.lat_valid = 1'b0;
      end else begin
         case (st.state)
            EPG_IDLE: begin
               if (next_st.wait_pend) begin
                  next_st.state     = EPG_WAIT;
                  next_st.wait_pend = 1'b0;
               end else if (prog_start && prog_allowed(st.lat_valid, st.protect)) begin
                  next_st.state = EPG_PROG;
                  next_st.cnt   = CNT_W'(PROG_CYCLES);
               end
            end
            EPG_PROG: begin
               if (st.cnt == CNT_W'(1)) begin
                  arr_wr            = 1'b1;
                  next_st.lat_valid = 1'b0;
                  next_st.cnt       = '0;
                  next_st.state     = next_st.wait_pend ? EPG_WAIT : EPG_IDLE;
                  next_st.wait_pend = 1'b0;
               end else begin
                  next_st.cnt = st.cnt - CNT_W'(1);
               end
            end
            EPG_WAIT, EPG_HALT: begin
               // A request seen while parked must not park the block again after wake.
               next_st.wait_pend = 1'b0;
               if (wake_event) begin
                  next_st.state = EPG_IDLE;
               end
            end
            EPG_ERASE: begin
               arr_clr           = 1'b1;
               next_st.protect   = 1'b0;
               next_st.lat_valid = 1'b0;
               next_st.state     = EPG_IDLE;
            end
            default: begin
               next_st.state = EPG_IDLE;
            end
         endcase
      end
      if (st.state != EPG_ERASE && readout_protect_opt) begin
         next_st.protect = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Reset abandons any programming cycle; stored bytes carry no guarantee.
         st.state     <= EPG_IDLE;
         st.wait_pend <= 1'b0;
         st.cnt       <= '0;
         st.lat_data  <= EPG_RESET_BYTE;
         st.lat_addr  <= '0;
         st.lat_valid <= 1'b0;
         st.rd_oe     <= 1'b0;
         st.protect   <= 1'b0;
         st.pm_erase  <= 1'b0;
      end else begin
         st.state     <= next_st.state;
         st.wait_pend <= next_st.wait_pend;
         st.cnt       <= next_st.cnt;
         st.lat_data  <= next_st.lat_data;
         st.lat_addr  <= next_st.lat_addr;
         st.lat_valid <= next_st.lat_valid;
         st.rd_oe     <= next_st.rd_oe;
         st.protect   <= next_st.protect;
         st.pm_erase  <= next_st.pm_erase;
      end
   end

   // Cell storage; a programmed byte lands on the last cycle of programming.
   epg_array u_array (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wr_en   (arr_wr),
      .clr_all (arr_clr),
      .wr_addr (st.lat_addr),
      .wr_data (st.lat_data),
      .rd_addr (bus_addr),
      .rd_data (bus_rdata)
   );

   assign bus_rdata_oe      = st.rd_oe;
   assign prog_busy         = (st.state == EPG_PROG);
   assign eeprom_in_wait    = (st.state == EPG_WAIT);
   assign eeprom_in_halt    = (st.state == EPG_HALT);
   assign program_mem_erase = st.pm_erase;
   assign protect_active    = st.protect;
endmodule // epg_guard

// ==== tb/epg_guard_properties.sv ====
// Port-level assertions for the EEPROM power and access guard.
`timescale 1ns/1ps
module epg_guard_chk
   import epg_pkg::*;
#(parameter int PROG_CYCLES = EPG_PROG_CYCLES) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic wait_for_interrupt_instr,
   input wire logic halt_instr,
   input wire logic prog_start,
   input wire logic bus_rd,
   input wire logic eeprom_latch_mode,
   input wire logic external_access,
   input wire logic bus_rdata_oe,
   input wire logic prog_busy,
   input wire logic eeprom_in_wait,
   input wire logic eeprom_in_halt,
   input wire logic program_mem_erase,
   input wire logic protect_active
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   int busy_len;
   always_ff @(posedge clk_sys) busy_len <= prog_busy ? busy_len + 1 : 0;
   a_wait_entry:
      assert property (wait_for_interrupt_instr && !prog_busy && !prog_start && !halt_instr && !eeprom_in_halt
         |=> eeprom_in_wait) else $error("wait not entered");
   a_no_wait_busy:
      assert property (!(prog_busy && eeprom_in_wait)) else $error("wait while busy");
   a_halt_abort:
      assert property (halt_instr |=> eeprom_in_halt && !prog_busy) else $error("halt late");
   a_latch_read:
      assert property (bus_rd && eeprom_latch_mode |=> !bus_rdata_oe) else $error("bus driven");
   a_prot_read:
      assert property (bus_rd && external_access && protect_active |=> !bus_rdata_oe) else $error("read leak");
   a_prot_prog:
      assert property (prog_start && protect_active && !prog_busy |=> !prog_busy) else $error("prog leak");
   a_busy_len:
      assert property ($fell(prog_busy) && !eeprom_in_halt |-> busy_len == PROG_CYCLES) else $error("busy len");
   a_erase_pulse:
      assert property (program_mem_erase |=> !program_mem_erase) else $error("erase too long");
endmodule // epg_guard_chk
bind epg_guard epg_guard_chk #(
   .PROG_CYCLES (PROG_CYCLES)
) chk (
   .clk_sys                  (clk_sys),
   .reset_n                  (reset_n),
   .wait_for_interrupt_instr (wait_for_interrupt_instr),
   .halt_instr               (halt_instr),
   .prog_start               (prog_start),
   .bus_rd                   (bus_rd),
   .eeprom_latch_mode        (eeprom_latch_mode),
   .external_access          (external_access),
   .bus_rdata_oe             (bus_rdata_oe),
   .prog_busy                (prog_busy),
   .eeprom_in_wait           (eeprom_in_wait),
   .eeprom_in_halt           (eeprom_in_halt),
   .program_mem_erase        (program_mem_erase),
   .protect_active           (protect_active)
);

// ==== tb/epg_cpu.sv ====
// Processor model that issues single bus reads and writes.
`timescale 1ns/1ps
module epg_cpu
   import epg_pkg::*;
(
   input  wire logic                  clk_sys,
   output logic                       bus_rd,
   output logic                       bus_wr,
   output logic      [EPG_ADDR_W-1:0] bus_addr,
   output logic      [EPG_DATA_W-1:0] bus_wdata
);
   initial begin
      bus_rd = 1'h0;
      bus_wr = 1'h0;
      bus_addr = 7'h00;
      bus_wdata = 8'h00;
   end
   // A released bus shows the inverse of the last value.
   task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      bus_wr = wr;
      bus_rd = !wr;
      bus_addr = a;
      bus_wdata = d;
      @(negedge clk_sys);
      bus_rd = 1'h0;
      bus_wr = 1'h0;
      bus_addr = ~a;
      bus_wdata = ~d;
   endtask
endmodule // epg_cpu

// ==== tb/test_epg_guard.sv ====
// Self-checking bench for the EEPROM power and access guard.
`timescale 1ns/1ps
module test_epg_guard
   import epg_pkg::*;
;
   localparam int PC = 4;
   logic clk_sys = 1'h0, reset_n, wait_for_interrupt_instr = 1'h0, active_halt_entry = 1'h0;
   logic halt_instr = 1'h0, wake_event = 1'h0, eeprom_latch_mode = 1'h0, prog_start = 1'h0;
   logic external_access = 1'h0, readout_protect_opt = 1'h0, option_reprogram = 1'h0, bus_rd, bus_wr;
   logic [6:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata;
   logic bus_rdata_oe, prog_busy, eeprom_in_wait, eeprom_in_halt, program_mem_erase, protect_active;
   int errors = 0, compares = 0, n;
   epg_guard #(
      .PROG_CYCLES (PC)
   ) uut (
      .clk_sys                  (clk_sys),
      .reset_n                  (reset_n),
      .wait_for_interrupt_instr (wait_for_interrupt_instr),
      .active_halt_entry        (active_halt_entry),
      .halt_instr               (halt_instr),
      .wake_event               (wake_event),
      .eeprom_latch_mode        (eeprom_latch_mode),
      .prog_start               (prog_start),
      .bus_rd                   (bus_rd),
      .bus_wr                   (bus_wr),
      .bus_addr                 (bus_addr),
      .bus_wdata                (bus_wdata),
      .external_access          (external_access),
      .readout_protect_opt      (readout_protect_opt),
      .option_reprogram         (option_reprogram),
      .bus_rdata                (bus_rdata),
      .bus_rdata_oe             (bus_rdata_oe),
      .prog_busy                (prog_busy),
      .eeprom_in_wait           (eeprom_in_wait),
      .eeprom_in_halt           (eeprom_in_halt),
      .program_mem_erase        (program_mem_erase),
      .protect_active           (protect_active)
   );
   epg_cpu cpu (
      .clk_sys   (clk_sys),
      .bus_rd    (bus_rd),
      .bus_wr    (bus_wr),
      .bus_addr  (bus_addr),
      .bus_wdata (bus_wdata)
   );
   always #50 clk_sys = ~clk_sys;
   task automatic chk(input string s, input logic [7:0] got, exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", s, exp, got);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = 1'h1;
      @(negedge clk_sys);
      s = 1'h0;
   endtask
   task automatic test_done;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic s_latch;
      eeprom_latch_mode = 1'h1;
      cpu.access(1'h0, 7'h05, 8'h00);
      chk("oe", bus_rdata_oe, 1'h0);
      eeprom_latch_mode = 1'h0;
      cpu.access(1'h1, 7'h05, 8'h3C);
      eeprom_latch_mode = 1'h1;
      pulse(prog_start);
      chk("busy", prog_busy, 1'h0);
   endtask
   task automatic s_prog;
      cpu.access(1'h1, 7'h05, 8'hA5);
      pulse(prog_start);
      chk("busy", prog_busy, 1'h1);
      pulse(wait_for_interrupt_instr);
      chk("wait", eeprom_in_wait, 1'h0);
      for (n = 2; prog_busy && n < 40; n++) @(negedge clk_sys);
      chk("cycles", n[7:0], 8'(PC));
      if (n >= 40) test_done();
      chk("wait", eeprom_in_wait, 1'h1);
      pulse(wake_event);
      eeprom_latch_mode = 1'h0;
      cpu.access(1'h0, 7'h05, 8'h00);
      chk("oe", bus_rdata_oe, 1'h1);
      chk("data", bus_rdata, 8'hA5);
   endtask
   task automatic s_halt;
      eeprom_latch_mode = 1'h1;
      cpu.access(1'h1, 7'h06, 8'h5A);
      pulse(prog_start);
      pulse(halt_instr);
      chk("halt", eeprom_in_halt, 1'h1);
      chk("busy", prog_busy, 1'h0);
      pulse(wake_event);
      pulse(active_halt_entry);
      chk("wait", eeprom_in_wait, 1'h1);
      pulse(wake_event);
      pulse(wait_for_interrupt_instr);
      chk("wait", eeprom_in_wait, 1'h1);
      pulse(wake_event);
   endtask
   task automatic s_prot;
      readout_protect_opt = 1'h1;
      external_access = 1'h1;
      eeprom_latch_mode = 1'h0;
      cpu.access(1'h0, 7'h05, 8'h00);
      chk("prot", protect_active, 1'h1);
      chk("oe", bus_rdata_oe, 1'h0);
      eeprom_latch_mode = 1'h1;
      cpu.access(1'h1, 7'h05, 8'h11);
      pulse(prog_start);
      chk("busy", prog_busy, 1'h0);
      external_access = 1'h0;
      cpu.access(1'h1, 7'h05, 8'h22);
      pulse(prog_start);
      chk("busy", prog_busy, 1'h0);
      readout_protect_opt = 1'h0;
      eeprom_latch_mode = 1'h0;
      pulse(option_reprogram);
      for (n = 0; n < 8 && !program_mem_erase; n++) @(negedge clk_sys);
      chk("erase", program_mem_erase, 1'h1);
      for (n = 0; n < 8 && protect_active; n++) @(negedge clk_sys);
      chk("prot", protect_active, 1'h0);
      cpu.access(1'h0, 7'h05, 8'h00);
      chk("data", bus_rdata, 8'hFF);
   endtask
   task automatic s_reset;
      eeprom_latch_mode = 1'h1;
      cpu.access(1'h1, 7'h07, 8'h3C);
      pulse(prog_start);
      chk("busy", prog_busy, 1'h1);
      reset_n = 1'h0;
      @(negedge clk_sys);
      chk("busy", prog_busy, 1'h0);
      repeat (3) @(negedge clk_sys);
      reset_n = 1'h1;
      repeat (3) @(negedge clk_sys);
      chk("busy", prog_busy, 1'h0);
      pulse(prog_start);
      chk("busy", prog_busy, 1'h0);
   endtask
   initial begin
      #1;
      reset_n = 1'h0;
      repeat (4) @(negedge clk_sys);
      reset_n = 1'h1;
      repeat (3) @(negedge clk_sys);
      s_latch();
      s_prog();
      s_halt();
      s_reset();
      s_prot();
      test_done();
   end
endmodule // test_epg_guard
